// ### src/smc_supply_monitor_control_regs.v
// Local design decision: the APB interface to the registers.
`include "smc_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module smc_supply_monitor_control_regs #(
   parameter FAST_CYC = `SMC_FAST_CYC,
   parameter SLOW_CYC = `SMC_SLOW_CYC
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Fuse values, stable during and after reset
   input wire fuse_rate,
   input wire [1:0] fuse_awake,
   input wire [1:0] fuse_dormant,
   input wire [2:0] fuse_level,
   // Power state and CPU instruction retire pulse
   input wire sleep_deep,
   input wire instr_retire,
   // Analog comparator, its controls, wake hold and interrupt
   input wire warn_below_raw,
   output reg detector_enable,
   output reg detector_sampled,
   output reg detector_strobe,
   output reg [2:0] threshold_level_code,
   output reg monitor_enable,
   output reg [1:0] warning_margin_select,
   output reg wake_hold,
   output reg warning_irq
);
   reg below_meta_reg;
   reg below_sync_reg;
   reg below_prev_reg;
   reg fuse_done_reg;
   reg sample_rate_select_reg;
   reg [1:0] awake_mode_reg;
   reg [1:0] dormant_mode_reg;
   reg [1:0] edge_reg;
   reg [1:0] margin_reg;
   reg [2:0] level_reg;
   reg irq_enable_reg;
   reg irq_flag_reg;
   reg status_reg;
   reg [2:0] unlock_cnt_reg;
   reg [2:0] unlock_cnt_next;
   reg [23:0] rate_cnt_reg;
   reg running_reg;
   reg [7:0] rd;

   wire [7:0] idx;
   wire access;
   wire wr;
   wire rd_acc;
   wire [1:0] mode_now;
   wire det_on;
   wire samp;
   wire [23:0] rate_top;
   wire tick;
   wire look;
   wire rise;
   wire fall;
   wire hit;
   wire clr;
   wire key_wr;
   wire mode_wr;

   assign idx = paddr[9:2];
   assign access = psel & penable & ~pready;
   assign wr = access & pwrite;
   assign rd_acc = access & ~pwrite;
   // Awake mode applies whenever the core is not in deep sleep.
   assign mode_now = sleep_deep ? dormant_mode_reg : awake_mode_reg;
   assign det_on = (mode_now != `SMC_MODE_OFF);
   assign samp = (mode_now == `SMC_MODE_SAMP);
   assign rate_top = sample_rate_select_reg ? (SLOW_CYC[23:0] - 24'h1) :
      (FAST_CYC[23:0] - 24'h1);
   assign tick = (rate_cnt_reg == rate_top);
   // Sampled mode looks at the comparator only on a tick.
   assign look = det_on & (~samp | tick);
   // Edges are taken between two looks, so a crossing between ticks is not lost.
   assign rise = below_sync_reg & ~below_prev_reg;
   assign fall = ~below_sync_reg & below_prev_reg;
   // Falling supply means the below signal rises.
   assign hit = look & irq_enable_reg & (
      ((edge_reg == `SMC_EDGE_FALL) & rise) |
      ((edge_reg == `SMC_EDGE_RISE) & fall) |
      ((edge_reg == `SMC_EDGE_BOTH) & (rise | fall)));
   assign clr = wr & (idx == `SMC_IDX_FLAGS) & pwdata[0];
   assign key_wr = wr & (idx == `SMC_IDX_PROT) & (pwdata[7:0] == `SMC_UNLOCK_KEY);
   assign mode_wr = wr & (idx == `SMC_IDX_MODE);

   // Read data for the current index.
   always @*
   begin
      rd = 8'h00;
      case (idx)
         `SMC_IDX_MODE:
            rd = {3'h0, sample_rate_select_reg, awake_mode_reg, dormant_mode_reg};
         `SMC_IDX_THR:
            rd = {5'h00, level_reg};
         `SMC_IDX_MARGIN:
            rd = {6'h00, margin_reg};
         `SMC_IDX_INTCTL:
            rd = {5'h00, edge_reg, irq_enable_reg};
         `SMC_IDX_FLAGS:
            rd = {7'h00, irq_flag_reg};
         `SMC_IDX_STATUS:
            rd = {7'h00, status_reg};
         default:
            rd = 8'h00;
      endcase
   end

   // The window counts retired instructions, not clocks.
   always @*
   begin
      unlock_cnt_next = unlock_cnt_reg;
      if (key_wr)
         unlock_cnt_next = `SMC_UNLOCK_WINDOW;
      else if (mode_wr & (unlock_cnt_reg != 3'h0))
         unlock_cnt_next = 3'h0;
      else if (instr_retire & (unlock_cnt_reg != 3'h0))
         unlock_cnt_next = unlock_cnt_reg - 3'h1;
      else
         unlock_cnt_next = unlock_cnt_reg;
   end

   // The comparator output is asynchronous and passes two flip-flops first.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         below_meta_reg <= 1'b0;
         below_sync_reg <= 1'b0;
         below_prev_reg <= 1'b0;
      end
      else
      begin
         below_meta_reg <= warn_below_raw;
         below_sync_reg <= below_meta_reg;
         if (look)
            below_prev_reg <= below_sync_reg;
      end
   end

   // Fuses are caught on the first edge after release.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fuse_done_reg <= 1'b0;
         sample_rate_select_reg <= 1'b0;
         awake_mode_reg <= `SMC_MODE_OFF;
         level_reg <= 3'h0;
      end
      else if (!fuse_done_reg)
      begin
         fuse_done_reg <= 1'b1;
         sample_rate_select_reg <= fuse_rate;
         awake_mode_reg <= fuse_awake;
         level_reg <= fuse_level;
      end
   end

   // Sample tick divider.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rate_cnt_reg <= 24'h0;
      end
      else
      begin
         rate_cnt_reg <= tick ? 24'h0 : (rate_cnt_reg + 24'h1);
      end
   end

   // Every access is answered one cycle after it is seen, never with an error.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= access;
         pslverr <= 1'b0;
         if (rd_acc)
            prdata <= {24'h0, rd};
      end
   end

   // Unlock window.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         unlock_cnt_reg <= 3'h0;
      end
      else
      begin
         unlock_cnt_reg <= unlock_cnt_next;
      end
   end

   // Rate and awake fields ignore writes with or without unlock.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dormant_mode_reg <= `SMC_MODE_OFF;
      end
      else if (!fuse_done_reg)
      begin
         dormant_mode_reg <= fuse_dormant;
      end
      else if (mode_wr & (unlock_cnt_reg != 3'h0))
      begin
         dormant_mode_reg <= pwdata[`SMC_DORM_HI:`SMC_DORM_LO];
      end
   end

   // Warning margin.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         margin_reg <= `SMC_MARGIN_RST;
      end
      else if (wr & (idx == `SMC_IDX_MARGIN))
      begin
         margin_reg <= pwdata[1:0];
      end
   end

   // Edge select and interrupt enable.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         edge_reg <= `SMC_EDGE_RST;
         irq_enable_reg <= 1'b0;
      end
      else if (wr & (idx == `SMC_IDX_INTCTL))
      begin
         edge_reg <= pwdata[`SMC_EDGE_HI:`SMC_EDGE_LO];
         irq_enable_reg <= pwdata[`SMC_IE_BIT];
      end
   end

   // A crossing in the clear cycle wins over the clear.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_flag_reg <= 1'b0;
      end
      else if (hit)
      begin
         irq_flag_reg <= 1'b1;
      end
      else if (clr)
      begin
         irq_flag_reg <= 1'b0;
      end
   end

   // Status is only refreshed while the detector looks.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         status_reg <= 1'b0;
      end
      else if (look)
      begin
         status_reg <= below_sync_reg;
      end
   end

   // Registered outputs to the analog side and the interrupt line.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         running_reg <= 1'b0;
         detector_enable <= 1'b0;
         detector_sampled <= 1'b0;
         detector_strobe <= 1'b0;
         threshold_level_code <= 3'h0;
         monitor_enable <= 1'b0;
         warning_margin_select <= 2'h0;
         wake_hold <= 1'b0;
         warning_irq <= 1'b0;
      end
      else
      begin
         // Hold mode releases once the detector has run one cycle.
         running_reg <= det_on;
         detector_enable <= det_on;
         detector_sampled <= samp;
         detector_strobe <= det_on & samp & tick;
         threshold_level_code <= level_reg;
         monitor_enable <= det_on & irq_enable_reg;
         warning_margin_select <= margin_reg;
         wake_hold <= ~sleep_deep & (awake_mode_reg == `SMC_MODE_HOLD) & ~running_reg;
         warning_irq <= irq_enable_reg & (irq_flag_reg | hit) & ~(clr & ~hit);
      end
   end
endmodule // smc_supply_monitor_control_regs
`default_nettype wire

// ### src/smc_consts.vh
`ifndef SMC_CONSTS_VH
`define SMC_CONSTS_VH
// Register indices; byte address is four times the index.
`define SMC_IDX_MODE 8'h00
`define SMC_IDX_THR 8'h01
`define SMC_IDX_MARGIN 8'h08
`define SMC_IDX_INTCTL 8'h09
`define SMC_IDX_FLAGS 8'h0a
`define SMC_IDX_STATUS 8'h0b
`define SMC_IDX_PROT 8'h10
// Field positions.
`define SMC_RATE_BIT 4
`define SMC_AWAKE_HI 3
`define SMC_AWAKE_LO 2
`define SMC_DORM_HI 1
`define SMC_DORM_LO 0
`define SMC_EDGE_HI 2
`define SMC_EDGE_LO 1
`define SMC_IE_BIT 0
// Reset values.
`define SMC_MARGIN_RST 2'h0
`define SMC_EDGE_RST 2'h0
// Detector modes.
`define SMC_MODE_OFF 2'h0
`define SMC_MODE_CONT 2'h1
`define SMC_MODE_SAMP 2'h2
`define SMC_MODE_HOLD 2'h3
// Warning edges.
`define SMC_EDGE_FALL 2'h0
`define SMC_EDGE_RISE 2'h1
`define SMC_EDGE_BOTH 2'h2
// Unlock key and window.
`define SMC_UNLOCK_KEY 8'hd8
`define SMC_UNLOCK_WINDOW 3'h4
// Sample rates.
`define SMC_CLK_HZ 100000000
`define SMC_FAST_HZ 1000
`define SMC_SLOW_HZ 125
`define SMC_FAST_CYC (`SMC_CLK_HZ / `SMC_FAST_HZ)
`define SMC_SLOW_CYC (`SMC_CLK_HZ / `SMC_SLOW_HZ)
`endif

// ### dv/smc_props.sv
`timescale 1ns/100ps
`default_nettype none
module smc_props (
   // Watched ports
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic [2:0] fuse_level,
   input wire logic [2:0] threshold_level_code,
   input wire logic detector_enable,
   input wire logic detector_sampled,
   input wire logic detector_strobe,
   input wire logic monitor_enable
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_acc;
      psel && penable && !pready;
   endsequence
   a_ready_next: assert property (s_acc |=> pready) else $error("late");
   a_ready_pulse: assert property (pready |=> !pready) else $error("long");
   a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper");
   a_level_fuse: assert property ($past(presetn, 2) |-> threshold_level_code == fuse_level)
      else $error("level");
   a_monitor_off: assert property (!detector_enable |-> !monitor_enable) else $error("mon");
   a_sampled_on: assert property (detector_sampled |-> detector_enable) else $error("samp");
   a_strobe_mode: assert property (detector_strobe |-> detector_sampled) else $error("strb");
   a_strobe_gap: assert property (detector_strobe |=> !detector_strobe [*7])
      else $error("gap");
endmodule // smc_props
bind smc_supply_monitor_control_regs smc_props u_props (.*);
`default_nettype wire

// ### dv/smc_supply_monitor_control_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module smc_supply_monitor_control_regs_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic instr_retire = 0, warn_below_raw = 0, fuse_rate = 0, sleep_deep = 0;
   wire logic detector_sampled;
   logic [31:0] paddr = 0, pwdata = 0, x = 32'ha493;
   logic [7:0] r, d;
   wire logic [31:0] prdata;
   wire logic pready, warning_irq;
   int n_mismatch = 0, checks = 0;
   smc_supply_monitor_control_regs #(.FAST_CYC(8), .SLOW_CYC(16)) dut (.*, .pslverr(),
      .fuse_awake(2'h2), .fuse_dormant(2'h2), .fuse_level(3'h7),
      .detector_enable(), .detector_strobe(),
      .threshold_level_code(), .monitor_enable(), .warning_margin_select(), .wake_hold());
   initial forever #5 pclk = ~pclk;
   initial #50000 summarize(1);
   function automatic logic [7:0] xs();
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x[7:0];
   endfunction
   task automatic cmp(input logic [7:0] e, g);
      checks++;
      n_mismatch += int'(g !== e);
      if (g !== e)
         $display("MISMATCH %0t exp %h got %h", $time, e, g);
   endtask
   // The request stays put until pready is seen, so slow answers are safe.
   task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] v);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, 22'h0, i, 2'h0, 24'h0, v};
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      r = prdata[7:0];
      {psel, penable} <= 2'b00;
   endtask
   task automatic summarize(input int late);
      n_mismatch += late;
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      d = xs();
      fuse_rate <= d[0];
      repeat (4) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      for (int i = 0; i < 7; i++)
      begin
         apb(0, 8'(i < 2 ? i : i + 6), 8'h0);
         cmp(i == 0 ? {3'h0, fuse_rate, 4'ha} : i == 1 ? 8'h07 : 8'h00, r);
      end
      for (int k = 0; k < 2; k++)
      begin
         apb(1, 8'h10, 8'hd8);
         repeat (5) @(posedge pclk) instr_retire <= (k == 0);
         @(posedge pclk) instr_retire <= 0;
         apb(1, 8'h00, 8'hfd);
         apb(0, 8'h00, 8'h0);
         cmp({3'h0, fuse_rate, (k == 0) ? 4'ha : 4'h9}, r);
      end
      for (int s = 0; s < 2; s++)
      begin
         @(posedge pclk) sleep_deep <= (s == 0);
         repeat (3) @(posedge pclk);
         cmp({7'h0, s == 1}, {7'h0, detector_sampled});
      end
      for (int e = 0; e < 3; e++)
      begin
         d = xs();
         apb(1, 8'h09, {d[7:3], 2'(e), 1'b1});
         @(posedge pclk) warn_below_raw <= !warn_below_raw;
         repeat (24) @(posedge pclk);
         cmp(8'h01, {7'h0, warning_irq});
         apb(0, 8'h0b, 8'h0);
         cmp({7'h0, warn_below_raw}, r);
         apb(1, 8'h0a, 8'hff);
         apb(0, 8'h0a, 8'h0);
         cmp(8'h00, r);
      end
      summarize(0);
   end
endmodule // smc_supply_monitor_control_regs_tb
`default_nettype wire
